// *** hw/periph_regs.sv ***
// Purpose: Common user-interface register bank of one peripheral
// Assumes: Single-cycle strobes from the bus master, no wait states
// Notes: Read data appear one cycle after the read strobe only
// Function
// - Word-only access, low address bits ignored
// - Decode own 16-Kbyte or 4-Kbyte window
// - Command register write-only, ones launch commands
// - Configuration read/write, resets to zero
// - Status read-only, writes change nothing
// - Enable write sets matching status bits
// - Disable write clears status, readable after
// - Zero bits in enable/disable ignored
// - Unused bits read as zero
// - Interrupt is OR of event status AND mask
// - Mask readable, changed via enable/disable
`timescale 1ns/1ps
`default_nettype none
module periph_regs #(
  parameter int CH_W = 8,
  parameter int EVT_W = 8,
  parameter int CMD_W = 8,
  parameter int CFG_W = 16,
  parameter int STAT_W = 8,
  parameter bit VIC_WINDOW = 1'b0,
  parameter logic [31:0] BASE_ADDR = 32'hFFFE_0000
) (
  input wire logic i_core_clk,
  input wire logic i_rstn,
  input wire logic [31:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr_stb,
  input wire logic i_rd_stb,
  output logic [31:0] o_rdata,
  input wire logic [STAT_W-1:0] i_periph_status,
  input wire logic [EVT_W-1:0] i_event,
  output logic [CMD_W-1:0] o_cmd_pulse,
  output logic [CFG_W-1:0] o_cfg,
  output logic [CH_W-1:0] o_ch_enabled,
  output logic o_irq
);
  // ==========================================================
  // Reset release
  // ==========================================================
  logic rstn_sync;

  reset_sync u_rst (
    .i_core_clk(i_core_clk),
    .i_rstn(i_rstn),
    .o_rstn(rstn_sync)
  );

  // ==========================================================
  // Address decode
  // ==========================================================
  localparam int WIN_BITS = VIC_WINDOW ? periph_regs_pkg::VIC_WIN_BITS : periph_regs_pkg::PERIPH_WIN_BITS;

  logic in_window;
  logic [13:0] offset;

  always_comb begin
    in_window = (i_addr[31:WIN_BITS] == BASE_ADDR[31:WIN_BITS]);
    offset = '0;
    offset[WIN_BITS-1:2] = i_addr[WIN_BITS-1:2];
  end

  logic wr_cmd, wr_cfg, wr_ch_en, wr_ch_dis, wr_irq_en, wr_irq_dis, wr_evt;

  always_comb begin
    wr_cmd = 1'b0;
    wr_cfg = 1'b0;
    wr_ch_en = 1'b0;
    wr_ch_dis = 1'b0;
    wr_irq_en = 1'b0;
    wr_irq_dis = 1'b0;
    wr_evt = 1'b0;
    if (i_wr_stb && in_window) begin
      if (offset == periph_regs_pkg::OFF_CMD) begin
        wr_cmd = 1'b1;
      end else if (offset == periph_regs_pkg::OFF_CFG) begin
        wr_cfg = 1'b1;
      end else if (offset == periph_regs_pkg::OFF_CH_EN) begin
        wr_ch_en = 1'b1;
      end else if (offset == periph_regs_pkg::OFF_CH_DIS) begin
        wr_ch_dis = 1'b1;
      end else if (offset == periph_regs_pkg::OFF_IRQ_EN) begin
        wr_irq_en = 1'b1;
      end else if (offset == periph_regs_pkg::OFF_IRQ_DIS) begin
        wr_irq_dis = 1'b1;
      end else if (offset == periph_regs_pkg::OFF_EVT_STAT) begin
        wr_evt = 1'b1;
      end
    end
  end

  // ==========================================================
  // Shadow banks
  // ==========================================================
  logic [CH_W-1:0] ch_state;
  logic [EVT_W-1:0] irq_mask;

  set_clear_bank #(
    .WIDTH(CH_W),
    .RESET_VAL(periph_regs_pkg::CH_RESET[CH_W-1:0])
  ) u_ch (
    .i_core_clk(i_core_clk),
    .i_rstn_sync(rstn_sync),
    .i_set_stb(wr_ch_en),
    .i_clr_stb(wr_ch_dis),
    .i_wdata(i_wdata[CH_W-1:0]),
    .o_state(ch_state)
  );

  set_clear_bank #(
    .WIDTH(EVT_W),
    .RESET_VAL(periph_regs_pkg::MASK_RESET[EVT_W-1:0])
  ) u_mask (
    .i_core_clk(i_core_clk),
    .i_rstn_sync(rstn_sync),
    .i_set_stb(wr_irq_en),
    .i_clr_stb(wr_irq_dis),
    .i_wdata(i_wdata[EVT_W-1:0]),
    .o_state(irq_mask)
  );

  // ==========================================================
  // Command, configuration, events, status sampling
  // ==========================================================
  logic [CMD_W-1:0] cmd_q, cmd_d;
  logic [CFG_W-1:0] cfg_q, cfg_d;
  logic [EVT_W-1:0] evt_q, evt_d;
  logic [STAT_W-1:0] stat_meta_q, stat_q;

  always_comb begin
    cmd_d = '0;
    if (wr_cmd) begin
      cmd_d = i_wdata[CMD_W-1:0];
    end
    cfg_d = cfg_q;
    if (wr_cfg) begin
      cfg_d = i_wdata[CFG_W-1:0];
    end
    evt_d = evt_q;
    if (wr_evt) begin
      evt_d = evt_q & ~i_wdata[EVT_W-1:0];
    end
    evt_d = evt_d | i_event;
  end

  always_ff @(posedge i_core_clk or negedge rstn_sync) begin
    if (!rstn_sync) begin
      cmd_q <= '0;
      cfg_q <= periph_regs_pkg::CFG_RESET[CFG_W-1:0];
      evt_q <= '0;
      stat_meta_q <= '0;
      stat_q <= '0;
    end else begin
      cmd_q <= cmd_d;
      cfg_q <= cfg_d;
      evt_q <= evt_d;
      stat_meta_q <= i_periph_status;
      stat_q <= stat_meta_q;
    end
  end

  // ==========================================================
  // Read path
  // ==========================================================
  logic [31:0] rdata_q, rdata_d;

  always_comb begin
    rdata_d = periph_regs_pkg::ZERO_WORD;
    if (i_rd_stb && in_window) begin
      if (offset == periph_regs_pkg::OFF_CFG) begin
        rdata_d[CFG_W-1:0] = cfg_q;
      end else if (offset == periph_regs_pkg::OFF_CH_STAT) begin
        rdata_d[CH_W-1:0] = ch_state;
      end else if (offset == periph_regs_pkg::OFF_STATUS) begin
        rdata_d[STAT_W-1:0] = stat_q;
      end else if (offset == periph_regs_pkg::OFF_IRQ_MASK) begin
        rdata_d[EVT_W-1:0] = irq_mask;
      end else if (offset == periph_regs_pkg::OFF_EVT_STAT) begin
        rdata_d[EVT_W-1:0] = evt_q;
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge rstn_sync) begin
    if (!rstn_sync) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // ==========================================================
  // Outputs
  // ==========================================================
  assign o_rdata = rdata_q;
  assign o_cmd_pulse = cmd_q;
  assign o_cfg = cfg_q;
  assign o_ch_enabled = ch_state;
  assign o_irq = |(evt_q & irq_mask);
endmodule
`default_nettype wire

// *** hw/periph_regs_pkg.sv ***
// Purpose: Shared constants for the peripheral register interface
// Assumes: 32-bit word-only peripheral bus, byte addresses
// Notes: Offsets are byte addresses inside one peripheral window
package periph_regs_pkg;

  // ==========================================================
  // Widths and windows
  // ==========================================================
  localparam int DATA_W = 32;
  localparam int ADDR_W = 32;
  localparam int PERIPH_WIN_BITS = 14;
  localparam int VIC_WIN_BITS = 12;

  // ==========================================================
  // Register offsets
  // ==========================================================
  localparam logic [13:0] OFF_CMD = 14'h0000;
  localparam logic [13:0] OFF_CFG = 14'h0004;
  localparam logic [13:0] OFF_CH_EN = 14'h0010;
  localparam logic [13:0] OFF_CH_DIS = 14'h0014;
  localparam logic [13:0] OFF_CH_STAT = 14'h0018;
  localparam logic [13:0] OFF_STATUS = 14'h001C;
  localparam logic [13:0] OFF_IRQ_EN = 14'h0020;
  localparam logic [13:0] OFF_IRQ_DIS = 14'h0024;
  localparam logic [13:0] OFF_IRQ_MASK = 14'h0028;
  localparam logic [13:0] OFF_EVT_STAT = 14'h002C;

  // ==========================================================
  // Reset values
  // ==========================================================
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;
  localparam logic [31:0] CH_RESET = 32'h0000_0000;
  localparam logic [31:0] MASK_RESET = 32'h0000_0000;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

endpackage

// *** hw/reset_sync.sv ***
// Purpose: Two-stage release synchroniser for the active-low reset
// Assumes: Asynchronous assertion
// Notes: Output deasserts two edges after input release
`timescale 1ns/1ps
`default_nettype none
module reset_sync (
  input wire logic i_core_clk,
  input wire logic i_rstn,
  output logic o_rstn
);
  logic meta_q;
  logic sync_q;

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= 1'b1;
      sync_q <= meta_q;
    end
  end

  assign o_rstn = sync_q;
endmodule
`default_nettype wire

// *** hw/set_clear_bank.sv ***
// Purpose: Enable/disable/status shadow bit bank
// Assumes: Set and clear strobes are one cycle, same clock
// Notes: Zero bits in either word leave state untouched
`timescale 1ns/1ps
`default_nettype none
module set_clear_bank #(
  parameter int WIDTH = 32,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic i_core_clk,
  input wire logic i_rstn_sync,
  input wire logic i_set_stb,
  input wire logic i_clr_stb,
  input wire logic [WIDTH-1:0] i_wdata,
  output logic [WIDTH-1:0] o_state
);
  logic [WIDTH-1:0] state_q;
  logic [WIDTH-1:0] state_d;

  always_comb begin
    state_d = state_q;
    if (i_set_stb) begin
      state_d = state_q | i_wdata;
    end else if (i_clr_stb) begin
      state_d = state_q & ~i_wdata;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn_sync) begin
    if (!i_rstn_sync) begin
      state_q <= RESET_VAL;
    end else begin
      state_q <= state_d;
    end
  end

  assign o_state = state_q;
endmodule
`default_nettype wire

// *** tb/cpu_bus_model.sv ***
// Purpose: Processor-side bus master for the register port
// Assumes: One-cycle strobes, no wait states
// Notes: Idle address toggles after every access, data after writes only, so stale values never match
`timescale 1ns/1ps
`default_nettype none
module cpu_bus_model (
  input wire logic i_core_clk,
  output logic [31:0] o_addr,
  output logic [31:0] o_wdata,
  output logic o_wr_stb,
  output logic o_rd_stb
);
  initial begin
    o_addr = '0;
    o_wdata = '0;
    o_wr_stb = 1'b0;
    o_rd_stb = 1'b0;
  end
  task automatic wr(input logic [31:0] adr, input logic [31:0] dat);
    @(posedge i_core_clk);
    o_addr <= adr;
    o_wdata <= dat;
    o_wr_stb <= 1'b1;
    @(posedge i_core_clk);
    o_wr_stb <= 1'b0;
    o_addr <= ~adr;
    o_wdata <= ~dat;
  endtask
  task automatic rd(input logic [31:0] adr);
    @(posedge i_core_clk);
    o_addr <= adr;
    o_rd_stb <= 1'b1;
    @(posedge i_core_clk);
    o_rd_stb <= 1'b0;
    o_addr <= ~adr;
  endtask
endmodule
`default_nettype wire

// *** tb/periph_regs_chk.sv ***
// Purpose: Port-level checker for the peripheral register bank
// Assumes: Window size follows the bound instance
// Notes: Attached to every periph_regs instance by bind
`timescale 1ns/1ps
`default_nettype none
module periph_regs_chk #(
  parameter int CH_W = 8,
  parameter int EVT_W = 8,
  parameter int CMD_W = 8,
  parameter int CFG_W = 16,
  parameter int STAT_W = 8,
  parameter bit VIC_WINDOW = 1'b0,
  parameter logic [31:0] BASE_ADDR = 32'hFFFE_0000
) (
  input wire logic i_core_clk,
  input wire logic i_rstn,
  input wire logic [31:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr_stb,
  input wire logic i_rd_stb,
  input wire logic [31:0] o_rdata,
  input wire logic [STAT_W-1:0] i_periph_status,
  input wire logic [EVT_W-1:0] i_event,
  input wire logic [CMD_W-1:0] o_cmd_pulse,
  input wire logic [CFG_W-1:0] o_cfg,
  input wire logic [CH_W-1:0] o_ch_enabled,
  input wire logic o_irq
);
  logic w;
  logic r;
  logic [11:0] a;
  localparam int WB = VIC_WINDOW ? 12 : 14;
  assign w = i_wr_stb && i_addr[31:WB] == BASE_ADDR[31:WB];
  assign r = i_rd_stb && i_addr[31:WB] == BASE_ADDR[31:WB];
  assign a = 12'(i_addr[WB-1:2]);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);
  AST_CMD: assert property (w && a == 0 |=> o_cmd_pulse == $past(i_wdata[CMD_W-1:0]))
    else $error("command pulse wrong");
  AST_CFG: assert property (w && a == 1 |=> o_cfg == $past(i_wdata[CFG_W-1:0]))
    else $error("config not written");
  AST_CFG_HOLD: assert property (!(w && a == 1) |=> $stable(o_cfg))
    else $error("config changed without write");
  AST_EN: assert property (w && a == 4 |=> (o_ch_enabled & $past(i_wdata[CH_W-1:0])) == $past(i_wdata[CH_W-1:0]))
    else $error("enable bits not set");
  AST_DIS: assert property (w && a == 5 |=> (o_ch_enabled & $past(i_wdata[CH_W-1:0])) == 0)
    else $error("disable bits not cleared");
  AST_CH_HOLD: assert property (!(w && (a == 4 || a == 5)) |=> $stable(o_ch_enabled))
    else $error("channel state changed");
  AST_RD_IDLE: assert property (!i_rd_stb |=> o_rdata == 0)
    else $error("read data outside read slot");
  AST_RD_CFG: assert property (r && a == 1 |=> o_rdata == 32'($past(o_cfg)))
    else $error("config read back wrong");
  AST_RD_WO: assert property (r && (a == 0 || a == 4 || a == 5 || a == 8 || a == 9) |=> o_rdata == 0)
    else $error("write-only place read nonzero");
endmodule
bind periph_regs periph_regs_chk #(.CH_W(CH_W), .EVT_W(EVT_W), .CMD_W(CMD_W), .CFG_W(CFG_W),
  .STAT_W(STAT_W), .VIC_WINDOW(VIC_WINDOW), .BASE_ADDR(BASE_ADDR)) chk (.i_core_clk, .i_rstn, .i_addr, .i_wdata, .i_wr_stb,
  .i_rd_stb, .o_rdata, .i_periph_status, .i_event, .o_cmd_pulse, .o_cfg, .o_ch_enabled, .o_irq);
`default_nettype wire

// *** tb/tb_top.sv ***
// Purpose: Self-checking bench for the register bank
// Assumes: Default parameters, base 0xFFFE0000
// Notes: Read results checked from a queue of expectations
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam logic [31:0] BASE = 32'hFFFE_0000;
  logic i_core_clk = 1'b0;
  logic i_rstn;
  logic [7:0] i_periph_status;
  logic [7:0] i_event;
  logic [31:0] i_addr, i_wdata, o_rdata, v;
  logic i_wr_stb, i_rd_stb, o_irq, rd_pend;
  logic [7:0] o_cmd_pulse, o_ch_enabled;
  logic [15:0] o_cfg;
  logic [31:0] exp_q[$];
  logic [13:0] wo[6] = '{14'h00, 14'h10, 14'h14, 14'h20, 14'h24, 14'h30};
  int mismatches = 0;
  int checked = 0;
  int seed = 10;
  always #20 i_core_clk = ~i_core_clk;
  cpu_bus_model cpu (.i_core_clk(i_core_clk), .o_addr(i_addr), .o_wdata(i_wdata), .o_wr_stb(i_wr_stb),
    .o_rd_stb(i_rd_stb));
  periph_regs DUT (.i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr_stb(i_wr_stb), .i_rd_stb(i_rd_stb), .o_rdata(o_rdata), .i_periph_status(i_periph_status),
    .i_event(i_event), .o_cmd_pulse(o_cmd_pulse), .o_cfg(o_cfg), .o_ch_enabled(o_ch_enabled), .o_irq(o_irq));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rdc(input logic [13:0] off, input logic [31:0] exp);
    exp_q.push_back(exp);
    cpu.rd(BASE | {18'h0, off});
  endtask
  task automatic wrc(input logic [13:0] off, input logic [31:0] dat);
    cpu.wr(BASE | {18'h0, off}, dat);
  endtask
  task automatic report_and_stop;
    $display("checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // ==========================================
  // Read result monitor
  // ==========================================
  always @(posedge i_core_clk) rd_pend <= i_rd_stb;
  always @(negedge i_core_clk) begin
    if (rd_pend && exp_q.size() > 0) chk(o_rdata, exp_q.pop_front());
  end
  initial begin
    #200000;
    mismatches++;
    report_and_stop();
  end
  // ==========================================
  // Scenarios
  // ==========================================
  initial begin
    i_rstn = 1'b0;
    i_event = 8'h00;
    i_periph_status = 8'h00;
    repeat (4) @(posedge i_core_clk);
    i_rstn <= 1'b1;
    repeat (3) @(posedge i_core_clk);
    rdc(14'h04, 32'h0);
    rdc(14'h18, 32'h0);
    rdc(14'h28, 32'h0);
    for (int i = 0; i < 4; i++) begin
      v = $random(seed) & 32'h0000_FFFF;
      wrc(14'h04 | 14'(i), v);
      rdc(14'h04, v);
    end
    cpu.wr(32'hFFFE_4004, 32'h1);
    wrc(14'h1C, 32'hFF);
    wrc(14'h18, 32'hFF);
    wrc(14'h28, 32'hFF);
    rdc(14'h04, v);
    rdc(14'h28, 32'h0);
    // Mid-run reset returns configuration to zero
    @(posedge i_core_clk) i_rstn <= 1'b0;
    repeat (2) @(posedge i_core_clk);
    i_rstn <= 1'b1;
    repeat (3) @(posedge i_core_clk);
    rdc(14'h04, 32'h0);
    wrc(14'h10, 32'h5);
    wrc(14'h10, 32'h2);
    wrc(14'h14, 32'h4);
    rdc(14'h18, 32'h3);
    @(negedge i_core_clk) chk({24'h0, o_ch_enabled}, 32'h3);
    wrc(14'h00, 32'hA5);
    @(negedge i_core_clk) chk({24'h0, o_cmd_pulse}, 32'hA5);
    @(negedge i_core_clk) chk({24'h0, o_cmd_pulse}, 32'h0);
    foreach (wo[k]) rdc(wo[k], 32'h0);
    @(posedge i_core_clk) i_periph_status <= 8'($random(seed));
    repeat (3) @(posedge i_core_clk);
    rdc(14'h1C, {24'h0, i_periph_status});
    @(posedge i_core_clk) i_event <= 8'h04;
    @(posedge i_core_clk) i_event <= 8'h00;
    @(negedge i_core_clk) chk({31'h0, o_irq}, 32'h0);
    rdc(14'h2C, 32'h4);
    wrc(14'h20, 32'h4);
    @(negedge i_core_clk) chk({31'h0, o_irq}, 32'h1);
    rdc(14'h28, 32'h4);
    wrc(14'h24, 32'h4);
    @(negedge i_core_clk) chk({31'h0, o_irq}, 32'h0);
    wrc(14'h20, 32'h4);
    wrc(14'h2C, 32'h4);
    @(negedge i_core_clk) chk({31'h0, o_irq}, 32'h0);
    rdc(14'h2C, 32'h0);
    // Event and clear in one cycle: the event wins
    fork
      wrc(14'h2C, 32'h4);
      @(posedge i_core_clk) i_event <= 8'h04;
    join
    i_event <= 8'h00;
    rdc(14'h2C, 32'h4);
    @(negedge i_core_clk) chk({31'h0, o_irq}, 32'h1);
    repeat (3) @(posedge i_core_clk);
    report_and_stop();
  end
endmodule
`default_nettype wire
